// ---- dgw_pkg.sv ----
// shared constants and functions for the display gate and window command link
package dgw_pkg;
    // command opcodes
    localparam logic [7:0] DGW_BLANK_OUTPUT_CMD = 8'h28;
    localparam logic [7:0] DGW_SHOW_OUTPUT_CMD = 8'h29;
    localparam logic [7:0] DGW_COLUMN_WINDOW_CMD = 8'h2A;
    localparam logic [7:0] DGW_PAGE_WINDOW_CMD = 8'h2B;
    localparam logic [7:0] DGW_FRAME_WRITE_CMD = 8'h2C;
    // byte index of the last window parameter
    localparam logic [1:0] DGW_LAST_PARAM = 2'h3;
    // strap settle count before window defaults are loaded
    localparam logic [1:0] DGW_STRAP_SETTLE = 2'h2;
    // resolution select codes
    localparam logic [2:0] DGW_RES_800 = 3'h0;
    localparam logic [2:0] DGW_RES_768 = 3'h1;
    localparam logic [2:0] DGW_RES_720 = 3'h2;
    localparam logic [2:0] DGW_RES_600 = 3'h3;
    // window values after reset
    localparam logic [15:0] DGW_START_RESET = 16'h0000;
    localparam logic [15:0] DGW_END_COL_800 = 16'h031F;
    localparam logic [15:0] DGW_END_COL_768 = 16'h02FF;
    localparam logic [15:0] DGW_END_COL_720 = 16'h02CF;
    localparam logic [15:0] DGW_END_COL_600 = 16'h0257;
    localparam logic [15:0] DGW_END_PAGE_1280 = 16'h04FF;
    localparam logic [15:0] DGW_END_PAGE_1024 = 16'h03FF;
    // panel output during blanking
    localparam logic [23:0] DGW_BLANK_PIXEL = 24'h000000;

    // last horizontal line index of a resolution (unknown codes fall back to the widest)
    function automatic logic [15:0] dgw_h_last(input logic [2:0] sel);
        case (sel)
            DGW_RES_768: dgw_h_last = DGW_END_COL_768;
            DGW_RES_720: dgw_h_last = DGW_END_COL_720;
            DGW_RES_600: dgw_h_last = DGW_END_COL_600;
            default: dgw_h_last = DGW_END_COL_800;
        endcase
    endfunction

    // last vertical line index of a resolution
    function automatic logic [15:0] dgw_v_last(input logic [2:0] sel);
        dgw_v_last = (sel == DGW_RES_600) ? DGW_END_PAGE_1024 : DGW_END_PAGE_1280;
    endfunction
endpackage

// ---- dgw_link_if.sv ----
// byte link between the host and the display command decoder
`timescale 1ns/1ps
interface dgw_link_if;
    logic [7:0] data; // command or parameter byte
    logic command_or_parameter_flag; // 0 command, 1 parameter
    logic wr_strobe; // high for one cycle per valid byte, held across back-to-back bytes

    // host drives the link
    modport host (
        output data,
        output command_or_parameter_flag,
        output wr_strobe
    );

    // display device receives it
    modport dev (
        input data,
        input command_or_parameter_flag,
        input wr_strobe
    );
endinterface

// ---- dgw_host.sv ----
// host end: sends display gate, window and frame write commands over the link
`timescale 1ns/1ps
module dgw_host
    import dgw_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // command request
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [15:0] cmd_start_in,
    input wire logic [15:0] cmd_end_in,
    output logic cmd_ready_out,
    output logic cmd_reject_out,
    // pixel stream after a frame write command
    input wire logic pixel_valid_in,
    input wire logic [7:0] pixel_in,
    output logic pixel_ready_out,
    // link
    dgw_link_if.host link
);
    typedef enum logic [1:0] {
        DGW_H_IDLE = 2'b01,
        DGW_H_SEND = 2'b10
    } dgw_host_state_t;

    dgw_host_state_t state;
    logic [39:0] shift;
    logic [2:0] left;
    logic streaming;
    logic first_byte;
    logic is_window;
    logic window_ok;
    logic [15:0] span;

    // window commands are checked before any byte leaves
    assign is_window = (cmd_code_in == DGW_COLUMN_WINDOW_CMD) ||
                       (cmd_code_in == DGW_PAGE_WINDOW_CMD);
    assign span = cmd_end_in - cmd_start_in + 16'h0001;
    assign window_ok = (cmd_start_in <= cmd_end_in) && !cmd_start_in[0] && !span[0]; // [R08] [R15] [R09] [R16]
    assign cmd_ready_out = (state == DGW_H_IDLE);
    // a pending command takes precedence so it can end the pixel stream
    assign pixel_ready_out = (state == DGW_H_IDLE) && streaming && !cmd_valid_in;

    // sequencer and byte shifter
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= DGW_H_IDLE;
            shift <= 40'h0000000000;
            left <= 3'h0;
            streaming <= 1'b0;
            first_byte <= 1'b0;
            cmd_reject_out <= 1'b0;
        end else begin
            cmd_reject_out <= 1'b0;
            case (state)
                DGW_H_IDLE: begin
                    if (cmd_valid_in) begin
                        if (is_window && !window_ok) begin
                            cmd_reject_out <= 1'b1; // illegal window never reaches the device
                        end else begin
                            shift <= {cmd_code_in, cmd_start_in, cmd_end_in};
                            left <= is_window ? 3'h5 : 3'h1;
                            streaming <= (cmd_code_in == DGW_FRAME_WRITE_CMD);
                            first_byte <= 1'b1; // next byte out is the opcode
                            state <= DGW_H_SEND;
                        end
                    end
                end
                DGW_H_SEND: begin
                    shift <= {shift[31:0], 8'h00};
                    left <= left - 3'h1;
                    first_byte <= 1'b0;
                    if (left == 3'h1) begin
                        state <= DGW_H_IDLE;
                    end
                end
                default: state <= DGW_H_IDLE;
            endcase
        end
    end

    // link outputs, registered
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            link.data <= 8'h00;
            link.command_or_parameter_flag <= 1'b1;
            link.wr_strobe <= 1'b0;
        end else if (state == DGW_H_SEND) begin
            link.data <= shift[39:32];
            // flag follows byte position, never byte value, so a zero parameter stays a parameter
            link.command_or_parameter_flag <= !first_byte;
            link.wr_strobe <= 1'b1;
        end else if (pixel_ready_out && pixel_valid_in) begin
            link.data <= pixel_in;
            link.command_or_parameter_flag <= 1'b1;
            link.wr_strobe <= 1'b1;
        end else begin
            link.wr_strobe <= 1'b0;
        end
    end
endmodule // dgw_host

// ---- dgw_device.sv ----
// device end: decodes display gate and window commands, steps the write window
// Summary of operation
// [R01] 28h blanks panel output, shows blank page
// [R02] gate change touches no memory, no status
// [R03] repeated 28h while blank has no effect
// [R04] 29h resumes frame memory output to panel
// [R05] repeated 29h while showing has no effect
// [R06] 2Ah takes four bytes: start, end column
// [R07] column values are lines; nothing else changes
// [R08] host keeps start column not above end
// [R09] host keeps start column, span even
// [R10] column beyond orientation limit: data ignored
// [R11] column reset: start 0, end by resolution
// [R12] column reset ends for selects 010, 011
// [R13] 2Bh takes four bytes: start, end page
// [R14] page values are lines; nothing else changes
// [R15] host keeps start page not above end
// [R16] host keeps start page, span even
// [R17] page beyond orientation limit: data ignored
// [R18] page reset: start 0, end by resolution
// [R19] frame write walks columns, then pages
// [R20] early command discards partial window update
`timescale 1ns/1ps
module dgw_device
    import dgw_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // link
    dgw_link_if.dev link,
    // straps and orientation
    input wire logic [2:0] resolution_select_in,
    input wire logic swap_axes_in,
    // panel path
    input wire logic [23:0] panel_pixel_in,
    output logic [23:0] panel_pixel_out,
    output logic display_on_out,
    // window state
    output logic [15:0] start_column_out,
    output logic [15:0] end_column_out,
    output logic [15:0] start_page_out,
    output logic [15:0] end_page_out,
    // frame memory write port
    output logic fm_write_out,
    output logic [15:0] fm_column_out,
    output logic [15:0] fm_page_out,
    output logic [7:0] fm_data_out
);
    typedef enum logic [3:0] {
        DGW_D_IDLE = 4'b0001,
        DGW_D_COLUMN = 4'b0010,
        DGW_D_PAGE = 4'b0100,
        DGW_D_FRAME = 4'b1000
    } dgw_dev_state_t;

    dgw_dev_state_t state;
    logic [2:0] res_meta;
    logic [2:0] res_sync;
    logic swap_meta;
    logic swap_sync;
    logic [1:0] settle;
    logic defaults_done;
    logic [1:0] param_idx;
    logic [23:0] staged;
    logic [15:0] start_column;
    logic [15:0] end_column;
    logic [15:0] start_page;
    logic [15:0] end_page;
    logic [15:0] cur_column;
    logic [15:0] cur_page;
    logic window_full;
    logic display_on;
    logic cmd_byte;
    logic param_byte;
    logic last_param;
    logic [15:0] new_start;
    logic [15:0] new_end;
    logic [15:0] col_limit;
    logic [15:0] page_limit;

    assign cmd_byte = link.wr_strobe && !link.command_or_parameter_flag;
    assign param_byte = link.wr_strobe && link.command_or_parameter_flag;
    assign last_param = param_byte && (param_idx == DGW_LAST_PARAM);
    assign new_start = staged[23:8];
    assign new_end = {staged[7:0], link.data};

    // straps and orientation come from pins, two flops before use
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            res_meta <= 3'h0;
            res_sync <= 3'h0;
            swap_meta <= 1'b0;
            swap_sync <= 1'b0;
        end else begin
            res_meta <= resolution_select_in;
            res_sync <= res_meta;
            swap_meta <= swap_axes_in;
            swap_sync <= swap_meta;
        end
    end

    // orientation picks which line count bounds each axis
    assign col_limit = swap_sync ? dgw_v_last(res_sync) : dgw_h_last(res_sync); // [R10]
    assign page_limit = swap_sync ? dgw_h_last(res_sync) : dgw_v_last(res_sync); // [R17]

    // command decoder; an unknown command simply returns to idle
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= DGW_D_IDLE;
            param_idx <= 2'h0;
            staged <= 24'h000000;
        end else if (cmd_byte) begin
            param_idx <= 2'h0; // partial window is dropped here [R20]
            case (link.data)
                DGW_COLUMN_WINDOW_CMD: state <= DGW_D_COLUMN; // [R06]
                DGW_PAGE_WINDOW_CMD: state <= DGW_D_PAGE; // [R13]
                DGW_FRAME_WRITE_CMD: state <= DGW_D_FRAME;
                default: state <= DGW_D_IDLE;
            endcase
        end else if (param_byte) begin
            case (state)
                DGW_D_COLUMN, DGW_D_PAGE: begin
                    staged <= {staged[15:0], link.data}; // high byte first [R06] [R13]
                    param_idx <= param_idx + 2'h1;
                    if (last_param) begin
                        state <= DGW_D_IDLE; // extra bytes are not a new window
                    end
                end
                DGW_D_IDLE, DGW_D_FRAME: begin
                    param_idx <= 2'h0;
                end
                default: state <= DGW_D_IDLE;
            endcase
        end
    end

    // window registers: defaults follow the settled strap, then host updates
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            settle <= 2'h0;
            defaults_done <= 1'b0;
            start_column <= DGW_START_RESET;
            end_column <= DGW_END_COL_800;
            start_page <= DGW_START_RESET;
            end_page <= DGW_END_PAGE_1280;
        end else if (!defaults_done) begin
            // reset cannot sample a pin, so the strap is caught once it has settled
            if (settle == DGW_STRAP_SETTLE) begin
                defaults_done <= 1'b1;
                start_column <= DGW_START_RESET; // [R11]
                end_column <= dgw_h_last(res_sync); // [R11] [R12]
                start_page <= DGW_START_RESET; // [R18]
                end_page <= dgw_v_last(res_sync); // [R18]
            end else begin
                settle <= settle + 2'h1;
            end
        end else if (last_param && state == DGW_D_COLUMN) begin
            start_column <= new_start; // only the column pair changes [R07]
            end_column <= new_end;
        end else if (last_param && state == DGW_D_PAGE) begin
            start_page <= new_start; // only the page pair changes [R14]
            end_page <= new_end;
        end
    end

    // display gate: setting an already-set state is harmless, so no guard needed
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            display_on <= 1'b0;
        end else if (cmd_byte && link.data == DGW_BLANK_OUTPUT_CMD) begin
            display_on <= 1'b0; // [R01] [R03]
        end else if (cmd_byte && link.data == DGW_SHOW_OUTPUT_CMD) begin
            display_on <= 1'b1; // [R04] [R05]
        end
    end

    // panel output; gating only, frame memory is never written here [R02]
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            panel_pixel_out <= DGW_BLANK_PIXEL;
        end else begin
            panel_pixel_out <= display_on ? panel_pixel_in : DGW_BLANK_PIXEL; // [R01] [R04]
        end
    end

    // frame write address walker
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cur_column <= DGW_START_RESET;
            cur_page <= DGW_START_RESET;
            window_full <= 1'b0;
        end else if (cmd_byte && link.data == DGW_FRAME_WRITE_CMD) begin
            cur_column <= start_column; // [R19]
            cur_page <= start_page;
            window_full <= 1'b0;
        end else if (param_byte && state == DGW_D_FRAME && !window_full) begin
            if (cur_column == end_column) begin
                cur_column <= start_column; // row done, next page [R19]
                if (cur_page == end_page) begin
                    window_full <= 1'b1; // bytes past the window are dropped
                end else begin
                    cur_page <= cur_page + 16'h0001;
                end
            end else begin
                cur_column <= cur_column + 16'h0001; // [R19]
            end
        end
    end

    // frame memory write strobe, suppressed outside the panel
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fm_write_out <= 1'b0;
            fm_column_out <= 16'h0000;
            fm_page_out <= 16'h0000;
            fm_data_out <= 8'h00;
        end else begin
            fm_write_out <= param_byte && state == DGW_D_FRAME && !window_full &&
                            cur_column <= col_limit && cur_page <= page_limit; // [R10] [R17]
            fm_column_out <= cur_column;
            fm_page_out <= cur_page;
            fm_data_out <= link.data;
        end
    end

    assign display_on_out = display_on;
    assign start_column_out = start_column;
    assign end_column_out = end_column;
    assign start_page_out = start_page;
    assign end_page_out = end_page;
endmodule // dgw_device

// ---- dgw_link_monitor.sv ----
// concurrent checks on the host to device command link and device outputs
`timescale 1ns/1ps
module dgw_link_monitor
    import dgw_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // link
    input wire logic [7:0] data,
    input wire logic command_or_parameter_flag,
    input wire logic wr_strobe,
    // device panel input and outputs
    input wire logic [23:0] panel_pixel_in,
    input wire logic [23:0] panel_pixel_out,
    input wire logic display_on_out,
    input wire logic [15:0] start_column_out,
    input wire logic [15:0] end_column_out,
    input wire logic [15:0] start_page_out,
    input wire logic [15:0] end_page_out,
    input wire logic fm_write_out,
    input wire logic [15:0] fm_column_out,
    input wire logic [15:0] fm_page_out
);
    default clocking mon_cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    // decoded link events, so each property reads as one relation
    logic op_off, op_on, op_col, op_page, prm;
    assign op_off = wr_strobe && !command_or_parameter_flag && data == DGW_BLANK_OUTPUT_CMD;
    assign op_on = wr_strobe && !command_or_parameter_flag && data == DGW_SHOW_OUTPUT_CMD;
    assign op_col = wr_strobe && !command_or_parameter_flag && data == DGW_COLUMN_WINDOW_CMD;
    assign op_page = wr_strobe && !command_or_parameter_flag && data == DGW_PAGE_WINDOW_CMD;
    assign prm = wr_strobe && command_or_parameter_flag;

    blank_cmd_a: assert property (op_off |=> !display_on_out)
        else $error("display still on after blank command");
    show_cmd_a: assert property (op_on |=> display_on_out)
        else $error("display still off after show command");
    blank_pix_a: assert property (!display_on_out |=> panel_pixel_out == DGW_BLANK_PIXEL)
        else $error("panel not blank while output is gated");
    show_pix_a: assert property (display_on_out |=> panel_pixel_out == $past(panel_pixel_in))
        else $error("panel does not follow frame memory");
    gate_hold_a: assert property ($changed(display_on_out) |-> $past(op_off || op_on))
        else $error("display gate moved without a gate command");
    win_hold_a: assert property ((op_off || op_on) |=>
        $stable({start_column_out, end_column_out, start_page_out, end_page_out}))
        else $error("gate command disturbed the window");
    col_load_a: assert property (op_col ##1 prm [*4] |=> {start_column_out, end_column_out}
        == {$past(data, 4), $past(data, 3), $past(data, 2), $past(data)})
        else $error("column window not loaded from its four bytes");
    page_load_a: assert property (op_page ##1 prm [*4] |=> {start_page_out, end_page_out}
        == {$past(data, 4), $past(data, 3), $past(data, 2), $past(data)})
        else $error("page window not loaded from its four bytes");
    col_walk_a: assert property (fm_write_out |->
        fm_column_out >= start_column_out && fm_column_out <= end_column_out)
        else $error("frame write column outside the window");
    page_walk_a: assert property (fm_write_out |->
        fm_page_out >= start_page_out && fm_page_out <= end_page_out)
        else $error("frame write page outside the window");
endmodule // dgw_link_monitor

// ---- tb_top.sv ----
// self-checking bench: host and device joined over the command link
`timescale 1ns/1ps
module tb_top;
    import dgw_pkg::*;
    // stimulus and observed signals
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_valid = 1'b0, pix_valid = 1'b0, swap = 1'b0, rej = 1'b0;
    logic [2:0] res = 3'h0;
    logic [7:0] cmd_code = 8'h00, pix = 8'h00, fm_data;
    logic [15:0] cmd_start = 16'h0000, cmd_end = 16'h0000;
    logic [23:0] ppix = 24'h000000, ppix_out;
    logic cmd_ready, cmd_reject, pix_ready, disp_on, fm_wr;
    logic [15:0] sc, ec, sp, ep, fm_col, fm_page, b_sc, b_ec, b_sp, b_ep;
    logic [15:0] m_sc, m_ec, m_sp, m_ep;
    logic [39:0] expq[$];
    integer seed = 32'hBEF6;
    integer n_mismatch = 0, cmp_count = 0;
    dgw_link_if link_a();
    dgw_link_if link_b();

    always #10 core_clk_in = ~core_clk_in;

    // link_a joins the two design ends, link_b is driven raw by the bench
    dgw_host dgw_host_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
        .cmd_code_in(cmd_code), .cmd_start_in(cmd_start), .cmd_end_in(cmd_end),
        .cmd_ready_out(cmd_ready), .cmd_reject_out(cmd_reject), .pixel_valid_in(pix_valid),
        .pixel_in(pix), .pixel_ready_out(pix_ready), .link(link_a));
    dgw_device dgw_device_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(link_a),
        .resolution_select_in(res), .swap_axes_in(swap), .panel_pixel_in(ppix),
        .panel_pixel_out(ppix_out), .display_on_out(disp_on), .start_column_out(sc),
        .end_column_out(ec), .start_page_out(sp), .end_page_out(ep), .fm_write_out(fm_wr),
        .fm_column_out(fm_col), .fm_page_out(fm_page), .fm_data_out(fm_data));
    dgw_device dgw_device_inst_b (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(link_b),
        .resolution_select_in(res), .swap_axes_in(swap), .panel_pixel_in(ppix),
        .panel_pixel_out(), .display_on_out(), .start_column_out(b_sc), .end_column_out(b_ec),
        .start_page_out(b_sp), .end_page_out(b_ep), .fm_write_out(), .fm_column_out(),
        .fm_page_out(), .fm_data_out());
    dgw_link_monitor dgw_link_monitor_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .data(link_a.data), .command_or_parameter_flag(link_a.command_or_parameter_flag),
        .wr_strobe(link_a.wr_strobe), .panel_pixel_in(ppix), .panel_pixel_out(ppix_out),
        .display_on_out(disp_on), .start_column_out(sc), .end_column_out(ec),
        .start_page_out(sp), .end_page_out(ep), .fm_write_out(fm_wr), .fm_column_out(fm_col),
        .fm_page_out(fm_page));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bounded wait for a handshake level, sampled mid-cycle where it has settled
    task automatic wait_hi(input bit pix_sel);
        int i = 0;
        logic s;
        do begin
            @(negedge core_clk_in);
            i++;
            s = pix_sel ? pix_ready : cmd_ready;
        end while (s !== 1'b1 && i < 200);
        if (s !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
    endtask

    function automatic logic [15:0] h_end(input logic [2:0] r);
        case (r)
            3'h1: return 16'h02FF;
            3'h2: return 16'h02CF;
            3'h3: return 16'h0257;
            default: return 16'h031F;
        endcase
    endfunction

    task automatic reset_to(input logic [2:0] r);
        @(posedge core_clk_in);
        res <= r;
        rst_in <= 1'b1;
        repeat (10) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (6) @(negedge core_clk_in);
        m_sc = 16'h0000;
        m_ec = h_end(r);
        m_sp = 16'h0000;
        m_ep = (r == 3'h3) ? 16'h03FF : 16'h04FF;
        cmp({sc, ec}, {m_sc, m_ec});
        cmp({sp, ep}, {m_sp, m_ep});
    endtask

    // one host request; rej records any refusal pulse after the take
    task automatic send(input logic [7:0] c, input logic [15:0] s, input logic [15:0] e);
        @(posedge core_clk_in);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_start <= s;
        cmd_end <= e;
        wait_hi(1'b0);
        @(posedge core_clk_in);
        cmd_valid <= 1'b0;
        rej = 1'b0;
        repeat (3) begin
            @(negedge core_clk_in);
            rej = rej | cmd_reject;
        end
        if (c != DGW_FRAME_WRITE_CMD) wait_hi(1'b0);
    endtask

    task automatic win(input logic [7:0] c, input logic [15:0] s, input logic [15:0] e);
        logic ok;
        ok = s <= e && !s[0] && e[0];
        send(c, s, e);
        cmp({31'h0, rej}, {31'h0, !ok});
        if (ok && c == DGW_COLUMN_WINDOW_CMD) {m_sc, m_ec} = {s, e};
        if (ok && c == DGW_PAGE_WINDOW_CMD) {m_sp, m_ep} = {s, e};
        repeat (2) @(negedge core_clk_in);
        cmp({sc, ec}, {m_sc, m_ec});
        cmp({sp, ep}, {m_sp, m_ep});
    endtask

    // frame write: the bench walks the window itself and queues the writes it expects
    task automatic frame(input int n);
        logic [15:0] c, p, cl, pl;
        logic [7:0] v;
        cl = swap ? ((res == 3'h3) ? 16'h03FF : 16'h04FF) : h_end(res);
        pl = swap ? h_end(res) : ((res == 3'h3) ? 16'h03FF : 16'h04FF);
        c = m_sc;
        p = m_sp;
        send(DGW_FRAME_WRITE_CMD, 16'h0000, 16'h0000);
        @(posedge core_clk_in);
        for (int i = 0; i < n; i++) begin
            v = 8'($random(seed));
            pix <= v;
            pix_valid <= 1'b1;
            wait_hi(1'b1);
            @(posedge core_clk_in);
            if (p <= m_ep && c <= cl && p <= pl) expq.push_back({c, p, v});
            c = (c == m_ec) ? m_sc : c + 16'h0001;
            p = (c == m_sc) ? p + 16'h0001 : p;
        end
        pix_valid <= 1'b0;
        repeat (4) @(negedge core_clk_in);
        cmp(expq.size(), 0);
        $display("frame test done");
    endtask

    // collector: every frame memory write must match the head of the queue
    always @(negedge core_clk_in) begin
        if (fm_wr === 1'b1) begin
            cmp({fm_col, fm_page}, expq.size() > 0 ? expq[0][39:8] : 32'hFFFFFFFF);
            cmp({24'h0, fm_data}, expq.size() > 0 ? {24'h0, expq[0][7:0]} : 32'h100);
            if (expq.size() > 0) void'(expq.pop_front());
        end
    end

    task automatic raw(input logic [7:0] b, input logic f);
        @(posedge core_clk_in);
        link_b.data <= b;
        link_b.command_or_parameter_flag <= f;
        link_b.wr_strobe <= 1'b1;
        @(posedge core_clk_in);
        link_b.wr_strobe <= 1'b0;
    endtask

    initial begin
        logic [15:0] s, e;
        logic [7:0] seq[6] = '{8'h28, 8'h28, 8'h29, 8'h29, 8'h28, 8'h29};
        link_b.data = 8'h00;
        link_b.command_or_parameter_flag = 1'b1;
        link_b.wr_strobe = 1'b0;
        for (int r = 3; r >= 0; r--) reset_to(3'(r));
        $display("reset test done");
        foreach (seq[k]) begin
            @(posedge core_clk_in);
            ppix <= 24'($random(seed));
            send(seq[k], 16'h0000, 16'h0000);
            repeat (2) @(negedge core_clk_in);
            cmp({31'h0, disp_on}, {31'h0, seq[k][0]});
            cmp({8'h0, ppix_out}, seq[k][0] ? {8'h0, ppix} : 32'h0);
            cmp({sc, ep}, {m_sc, m_ep});
        end
        $display("gate test done");
        win(DGW_COLUMN_WINDOW_CMD, 16'h0000, 16'h0001);
        win(DGW_COLUMN_WINDOW_CMD, 16'hFFFE, 16'hFFFF);
        win(DGW_PAGE_WINDOW_CMD, 16'h0006, 16'h0005);
        win(DGW_PAGE_WINDOW_CMD, 16'h0004, 16'h0004);
        for (int i = 0; i < 24; i++) begin
            s = 16'($random(seed)) & 16'h07FE;
            e = s + (16'($random(seed)) & 16'h00FE) + 16'h0001;
            if (i % 4 == 0) s = s ^ 16'h0001;
            if (i % 4 == 1) e = s - 16'h0001;
            win(i[0] ? DGW_PAGE_WINDOW_CMD : DGW_COLUMN_WINDOW_CMD, s, e);
        end
        $display("window test done");
        win(DGW_COLUMN_WINDOW_CMD, 16'h0002, 16'h0005);
        win(DGW_PAGE_WINDOW_CMD, 16'h0004, 16'h0005);
        frame(10);
        win(DGW_COLUMN_WINDOW_CMD, 16'h031E, 16'h0321);
        win(DGW_PAGE_WINDOW_CMD, 16'h04FE, 16'h04FF);
        frame(8);
        @(posedge core_clk_in);
        swap <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        frame(8);
        // partial column update cut short by a command, then a page update with a stray byte
        raw(8'h2A, 1'b0);
        raw(8'h00, 1'b1);
        raw(8'h10, 1'b1);
        raw(8'h28, 1'b0);
        raw(8'h00, 1'b1);
        raw(8'h20, 1'b1);
        raw(8'h2B, 1'b0);
        raw(8'h00, 1'b1);
        raw(8'h02, 1'b1);
        raw(8'h00, 1'b1);
        raw(8'h07, 1'b1);
        raw(8'h09, 1'b1);
        repeat (3) @(negedge core_clk_in);
        cmp({b_sc, b_ec}, {16'h0000, h_end(res)});
        cmp({b_sp, b_ep}, 32'h00020007);
        $display("partial update test done");
        summarize();
    end
endmodule // tb_top
